//--- core/rmf_pkg.sv
// package: constants and types for the relay modulator and fault output
package rmf_pkg;

   // register offsets (word index on plain port)
   localparam logic [3:0] REG_CTRL      = 4'h0; // function, mode, part, hold, diag mode
   localparam logic [3:0] REG_CYCLE     = 4'h1; // cycle length, tenths of a second
   localparam logic [3:0] REG_MIN_ON    = 4'h2; // minimum on-time, tenths of a second
   localparam logic [3:0] REG_MAX_RATE  = 4'h3; // maximum pulses per minute
   localparam logic [3:0] REG_FIX_VAL   = 4'h4; // hold fixed value
   localparam logic [3:0] REG_MSG_MAP   = 4'h5; // individual message mask
   localparam logic [3:0] REG_CAT_SEL   = 4'h6; // message index for category access, write and read
   localparam logic [3:0] REG_CAT_VAL   = 4'h7; // category of selected message
   localparam logic [3:0] REG_STATUS    = 4'h8; // relay and fault state

   // control field positions
   localparam int CTRL_FUNC_LSB = 0;  // 2 bits
   localparam int CTRL_MODE_BIT = 2;
   localparam int CTRL_PART_LSB = 3;  // 2 bits
   localparam int CTRL_HOLD_LSB = 5;  // 2 bits
   localparam int CTRL_DIAG_LSB = 7;  // 3 bits

   // timing in tenths of a second
   localparam logic [13:0] CYCLE_MAX      = 14'h2706; // 999.0 s
   localparam logic [13:0] MIN_ON_LOW     = 14'h0003; // 0.3 s
   localparam logic [13:0] CYCLE_RESET    = 14'h0064; // 10.0 s
   localparam logic [7:0]  RATE_LOW       = 8'h01;
   localparam logic [7:0]  RATE_HIGH      = 8'hb4;    // 180 per minute
   localparam logic [7:0]  RATE_RESET     = 8'h3c;    // 60 per minute
   localparam logic [13:0] TENTHS_PER_MIN = 14'h0258; // 600 tenths
   localparam real         TICK_S         = 0.1;      // tick period in seconds
   localparam real         CLK_HZ         = 250.0e6;
   localparam int          TICK_CYCLES    = int'(TICK_S * CLK_HZ);

   // manipulated variable full scale
   localparam logic [15:0] MV_FULL = 16'h7fff;

   typedef enum logic [1:0] {
      FN_OFF   = 2'b00,
      FN_CTRL  = 2'b01,
      FN_DIAG  = 2'b10
   } rmf_func_type;

   typedef enum logic [1:0] {
      PART_NONE = 2'b00,
      PART_NEG  = 2'b01,
      PART_POS  = 2'b10
   } rmf_part_type;

   typedef enum logic [1:0] {
      HOLD_FREEZE = 2'b00,
      HOLD_FIXED  = 2'b01,
      HOLD_IGNORE = 2'b10
   } rmf_hold_type;

   typedef enum logic [2:0] {
      DG_ASSIGNED = 3'b000,
      DG_CAT_M    = 3'b001,
      DG_CAT_S    = 3'b010,
      DG_CAT_C    = 3'b011,
      DG_CAT_F    = 3'b100
   } rmf_diag_type;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ON   = 2'b01,
      PH_OFF  = 2'b10
   } rmf_phase_type;

endpackage : rmf_pkg

//--- core/rmf_fault_sel.sv
// module: fault message selection for a diagnostic relay
`timescale 1ns/1ps
`default_nettype none

module rmf_fault_sel #(
   parameter int N_MSG = 16
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // messages and mapping
   input  wire logic [N_MSG-1:0]   msg_i,
   input  wire logic [N_MSG-1:0]   assign_mask_i,
   input  wire logic [2*N_MSG-1:0] cat_map_i,
   input  wire logic [2:0]         diag_mode_i,
   // result
   output logic                    fault_o
);

   typedef struct packed {
      logic fault;
   } rmf_fs_state_type;

   rmf_fs_state_type s_q;
   rmf_fs_state_type s_d;

   // any message active in the chosen selection
   always_comb begin
      s_d = s_q;
      s_d.fault = 1'b0;
      for (int i = 0; i < N_MSG; i++) begin
         if (diag_mode_i == rmf_pkg::DG_ASSIGNED) begin
            if (msg_i[i] && assign_mask_i[i]) s_d.fault = 1'b1;
         end else begin
            if (msg_i[i] && ({1'b0, cat_map_i[2*i +: 2]} == diag_mode_i - 3'h1)) begin
               s_d.fault = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) s_q <= '0;
      else       s_q <= s_d;
   end

   assign fault_o = s_q.fault;

endmodule : rmf_fault_sel

`default_nettype wire

//--- core/rmf_relay.sv
// module: relay modulator with fail-safe diagnostic and alarm relay output
//
// Overview of operation
// - width mode: fixed period, only the energized fraction varies
// - frequency mode: fixed pulse length, gap varies with the variable
// - frequency mode at full-scale variable: gap equals pulse length
// - part select none, decreasing or increasing; none after reset
// - increasing part drives relay from positive variable
// - decreasing part drives relay from negative variable
// - cycle length configurable from minimum on-time to 999.0 s
// - cycle length never below minimum on-time
// - minimum on-time 0.3 s up to cycle length, default 0.3 s
// - width mode: pulses shorter than minimum on-time are suppressed for that cycle
// - maximum rate 1 to 180 per minute, default 60
// - frequency pulse length derived from maximum rate
// - diagnostic relay energized while no selected fault active
// - alarm relay always fail-safe
// - diagnostic source is one of 4 categories or individual set
// - individual mode: any mapped active message de-energizes
// - category mode: any message in category de-energizes; mapping configurable
// - after reset relay individual mode, alarm relay failure category
// - individual mapping writable only while function is diagnostics
// - each cycle is energized pulse then de-energized interval
// - mode width or frequency; width after reset
// - hold behaviour freeze, fixed value or ignore
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module rmf_relay #(
   parameter int N_MSG       = 16,
   parameter int TICK_CYCLES = rmf_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic               SYS_CLK_I,
   input  wire logic               RST_I,
   // register port
   input  wire logic [3:0]         ADDR_I,
   input  wire logic [31:0]        WDATA_I,
   input  wire logic               WR_I,
   input  wire logic               RD_I,
   output logic      [31:0]        RDATA_O,
   // controller and diagnostics
   input  wire logic signed [15:0] MV_I,
   input  wire logic               HOLD_I,
   input  wire logic [N_MSG-1:0]   MSG_I,
   // relay coils
   output logic                    RELAY_O,
   output logic                    ALARM_RELAY_O
);

   localparam int TW = 14; // tenths width
   localparam logic [TW-1:0] ONE_T = 14'h0001;

   typedef struct packed {
      logic [1:0]           func;
      logic                 pfm;
      logic [1:0]           part;
      logic [1:0]           hold;
      logic [2:0]           diag;
      logic [TW-1:0]        cycle;
      logic [TW-1:0]        min_on;
      logic [7:0]           rate;
      logic [15:0]          fix_val;
      logic [N_MSG-1:0]     mask;
      logic [2*N_MSG-1:0]   cat_map;
      logic [7:0]           cat_idx;
      logic [15:0]          mv_held;
      logic [31:0]          tick_cnt;
      logic [1:0]           phase;
      logic [TW-1:0]        remain;
      logic [TW-1:0]        on_len;   // on-time latched at cycle start
      logic                 relay;
      logic                 alarm;
      logic [31:0]          rdata;
   } rmf_state_type;

   rmf_state_type s_q;
   rmf_state_type s_d;

   logic fault_relay;
   logic fault_alarm;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // clamp a signed value to zero through full scale
   function automatic logic [15:0] clamp_mv(input logic signed [16:0] v);
      if (v < 0)                               clamp_mv = 16'h0000;
      else if (v > $signed({1'b0, rmf_pkg::MV_FULL})) clamp_mv = rmf_pkg::MV_FULL;
      else                                     clamp_mv = v[15:0];
   endfunction : clamp_mv

   // scale a duration by the unipolar fraction
   function automatic logic [TW-1:0] scale_t(input logic [TW-1:0] t, input logic [15:0] f);
      logic [31:0] p;
      p = 32'(t) * 32'(f);
      scale_t = TW'(p / 32'(rmf_pkg::MV_FULL));
   endfunction : scale_t

   ////////////////////////////////////////////////////////////////////////////
   // fault selection: relay and alarm relay

   rmf_fault_sel #(.N_MSG(N_MSG)) u_fs_relay (
      .clk_i         (SYS_CLK_I),
      .rst_i         (RST_I),
      .msg_i         (MSG_I),
      .assign_mask_i (s_q.mask),
      .cat_map_i     (s_q.cat_map),
      .diag_mode_i   (s_q.diag),
      .fault_o       (fault_relay)
   );

   rmf_fault_sel #(.N_MSG(N_MSG)) u_fs_alarm (
      .clk_i         (SYS_CLK_I),
      .rst_i         (RST_I),
      .msg_i         (MSG_I),
      .assign_mask_i ('0),
      .cat_map_i     (s_q.cat_map),
      .diag_mode_i   (rmf_pkg::DG_CAT_F),
      .fault_o       (fault_alarm)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic signed [16:0] part_v;
      logic [15:0]        frac;
      logic [TW-1:0]      on_t;
      logic [TW-1:0]      off_t;
      logic [TW-1:0]      pulse_t;
      logic [TW-1:0]      wcyc;
      logic [TW-1:0]      wmin;
      logic               tick;
      part_v  = '0;
      frac    = '0;
      on_t    = '0;
      off_t   = '0;
      pulse_t = '0;
      wcyc    = '0;
      wmin    = '0;
      tick    = 1'b0;
      s_d = s_q;
      s_d.rdata = '0;

      // register writes
      if (WR_I) begin
         unique case (ADDR_I)
            rmf_pkg::REG_CTRL: begin
               s_d.func = WDATA_I[rmf_pkg::CTRL_FUNC_LSB +: 2];
               s_d.pfm  = WDATA_I[rmf_pkg::CTRL_MODE_BIT];
               s_d.part = WDATA_I[rmf_pkg::CTRL_PART_LSB +: 2];
               s_d.hold = WDATA_I[rmf_pkg::CTRL_HOLD_LSB +: 2];
               if (WDATA_I[rmf_pkg::CTRL_DIAG_LSB +: 3] <= rmf_pkg::DG_CAT_F)
                  s_d.diag = WDATA_I[rmf_pkg::CTRL_DIAG_LSB +: 3];
            end
            rmf_pkg::REG_CYCLE: begin
               wcyc = WDATA_I[TW-1:0];
               if (wcyc > rmf_pkg::CYCLE_MAX) wcyc = rmf_pkg::CYCLE_MAX;
               if (wcyc < s_q.min_on)         wcyc = s_q.min_on;
               s_d.cycle = wcyc;
            end
            rmf_pkg::REG_MIN_ON: begin
               wmin = WDATA_I[TW-1:0];
               if (wmin < rmf_pkg::MIN_ON_LOW) wmin = rmf_pkg::MIN_ON_LOW;
               if (wmin > s_q.cycle)           wmin = s_q.cycle;
               s_d.min_on = wmin;
            end
            rmf_pkg::REG_MAX_RATE: begin
               if (WDATA_I[7:0] < rmf_pkg::RATE_LOW)       s_d.rate = rmf_pkg::RATE_LOW;
               else if (WDATA_I[7:0] > rmf_pkg::RATE_HIGH) s_d.rate = rmf_pkg::RATE_HIGH;
               else                                        s_d.rate = WDATA_I[7:0];
            end
            rmf_pkg::REG_FIX_VAL: s_d.fix_val = WDATA_I[15:0];
            rmf_pkg::REG_MSG_MAP: begin
               if (s_q.func == rmf_pkg::FN_DIAG) s_d.mask = WDATA_I[N_MSG-1:0];
            end
            rmf_pkg::REG_CAT_SEL: s_d.cat_idx = WDATA_I[7:0];
            rmf_pkg::REG_CAT_VAL: begin
               if (32'(s_q.cat_idx) < N_MSG)
                  s_d.cat_map[2*s_q.cat_idx +: 2] = WDATA_I[1:0];
            end
            default: ;
         endcase
      end

      // register reads, data in the following cycle
      if (RD_I) begin
         unique case (ADDR_I)
            rmf_pkg::REG_CTRL: s_d.rdata = 32'({s_q.diag, s_q.hold, s_q.part, s_q.pfm, s_q.func});
            rmf_pkg::REG_CYCLE:    s_d.rdata = 32'(s_q.cycle);
            rmf_pkg::REG_MIN_ON:   s_d.rdata = 32'(s_q.min_on);
            rmf_pkg::REG_MAX_RATE: s_d.rdata = 32'(s_q.rate);
            rmf_pkg::REG_FIX_VAL:  s_d.rdata = 32'(s_q.fix_val);
            rmf_pkg::REG_MSG_MAP:  s_d.rdata = 32'(s_q.mask);
            rmf_pkg::REG_CAT_SEL:  s_d.rdata = 32'(s_q.cat_idx);
            rmf_pkg::REG_CAT_VAL: begin
               if (32'(s_q.cat_idx) < N_MSG) s_d.rdata = 32'(s_q.cat_map[2*s_q.cat_idx +: 2]);
            end
            rmf_pkg::REG_STATUS:
               s_d.rdata = 32'({fault_alarm, fault_relay, s_q.phase, s_q.alarm, s_q.relay});
            default: s_d.rdata = '0;
         endcase
      end

      // tenth-second tick
      if (s_q.tick_cnt == 32'(TICK_CYCLES - 1)) begin
         s_d.tick_cnt = '0;
         tick = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 32'h1;
      end

      // hold behaviour on the manipulated variable
      if (!HOLD_I || s_q.hold == rmf_pkg::HOLD_IGNORE) begin
         s_d.mv_held = MV_I;
      end else if (s_q.hold == rmf_pkg::HOLD_FIXED) begin
         s_d.mv_held = s_q.fix_val;
      end

      // unipolar part select and clamp
      if (s_q.part == rmf_pkg::PART_POS) part_v = 17'(signed'(s_q.mv_held));
      else if (s_q.part == rmf_pkg::PART_NEG)
         part_v = -17'(signed'(s_q.mv_held));
      frac = clamp_mv(part_v);

      // on-time and gap for the coming cycle
      if (!s_q.pfm) begin
         on_t  = scale_t(s_q.cycle, frac);
         if (on_t < s_q.min_on) on_t = '0;
         off_t = s_q.cycle - on_t;
      end else begin
         pulse_t = TW'(rmf_pkg::TENTHS_PER_MIN / TW'(s_q.rate >> 0) / TW'(2));
         if (pulse_t == '0) pulse_t = ONE_T;
         on_t = (frac == '0) ? '0 : pulse_t;
         if (frac == '0) off_t = pulse_t;
         else off_t = TW'(32'(pulse_t) * 32'(rmf_pkg::MV_FULL) / 32'(frac));
      end

      // phase sequencing, on-time latched at cycle start, frequency-mode gap at pulse end
      if (s_q.func != rmf_pkg::FN_CTRL || s_q.part == rmf_pkg::PART_NONE) begin
         s_d.phase  = rmf_pkg::PH_IDLE;
         s_d.remain = '0;
      end else if (tick) begin
         if (s_q.remain > ONE_T) begin
            s_d.remain = s_q.remain - ONE_T;
         end else begin
            unique case (s_q.phase)
               rmf_pkg::PH_ON: begin
                  s_d.phase  = rmf_pkg::PH_OFF;
                  // width mode keeps the period: gap from the latched on-time
                  s_d.remain = s_q.pfm ? off_t : s_q.cycle - s_q.on_len;
               end
               default: begin
                  s_d.phase  = (on_t == '0) ? rmf_pkg::PH_OFF : rmf_pkg::PH_ON;
                  s_d.remain = (on_t == '0) ? ((off_t == '0) ? ONE_T : off_t) : on_t;
                  s_d.on_len = on_t;
               end
            endcase
         end
      end

      // relay drive
      unique case (s_q.func)
         rmf_pkg::FN_CTRL: s_d.relay = (s_q.phase == rmf_pkg::PH_ON);
         rmf_pkg::FN_DIAG: s_d.relay = !fault_relay;
         default:          s_d.relay = 1'b0;
      endcase
      s_d.alarm = !fault_alarm;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s_q        <= '0;
         s_q.func   <= rmf_pkg::FN_OFF;
         s_q.pfm    <= 1'b0;
         s_q.part   <= rmf_pkg::PART_NONE;
         s_q.hold   <= rmf_pkg::HOLD_IGNORE;
         s_q.diag   <= rmf_pkg::DG_ASSIGNED;
         s_q.cycle  <= rmf_pkg::CYCLE_RESET;
         s_q.min_on <= rmf_pkg::MIN_ON_LOW;
         s_q.rate   <= rmf_pkg::RATE_RESET;
         s_q.phase  <= rmf_pkg::PH_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs from flip-flops
   assign RDATA_O       = s_q.rdata;
   assign RELAY_O       = s_q.relay;
   assign ALARM_RELAY_O = s_q.alarm;

endmodule : rmf_relay

`default_nettype wire

//--- tb/rmf_relay_assertions.sv
// checker: port-level properties of the relay modulator
`timescale 1ns/1ps
`default_nettype none

module rmf_relay_checker #(
   parameter int N_MSG = 16
) (
   // clock and reset
   input  wire logic             SYS_CLK_I,
   input  wire logic             RST_I,
   // register port
   input  wire logic [3:0]       ADDR_I,
   input  wire logic [31:0]      WDATA_I,
   input  wire logic             WR_I,
   input  wire logic             RD_I,
   input  wire logic [31:0]      RDATA_O,
   // messages and coils
   input  wire logic [N_MSG-1:0] MSG_I,
   input  wire logic             RELAY_O,
   input  wire logic             ALARM_RELAY_O
);
   logic [9:0]       ctrl_q;
   logic [N_MSG-1:0] mask_q;
   logic [1:0]       cat_q [N_MSG];
   logic [7:0]       sel_q;
   logic             f_rel;
   logic             f_alm;
   logic             diag;

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   ////////////////////////////////////////////////////////////////////////////
   // shadow of the configuration as written on the port
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_q <= 10'h040;
         mask_q <= '0;
         sel_q  <= 8'h00;
         for (int i = 0; i < N_MSG; i++) cat_q[i] <= 2'h0;
      end else if (WR_I) begin
         if (ADDR_I == rmf_pkg::REG_CTRL) ctrl_q <= WDATA_I[9:0];
         if (ADDR_I == rmf_pkg::REG_MSG_MAP && ctrl_q[1:0] == 2'h2) mask_q <= WDATA_I[N_MSG-1:0];
         if (ADDR_I == rmf_pkg::REG_CAT_SEL) sel_q <= WDATA_I[7:0];
         if (ADDR_I == rmf_pkg::REG_CAT_VAL) cat_q[sel_q] <= WDATA_I[1:0];
      end
   end

   // expected fault of relay and alarm relay
   always_comb begin
      f_rel = (ctrl_q[9:7] == 3'h0) && (|(MSG_I & mask_q));
      f_alm = 1'b0;
      for (int i = 0; i < N_MSG; i++) begin
         if (MSG_I[i] && cat_q[i] == 2'h3) f_alm = 1'b1;
         if (MSG_I[i] && {1'b0, cat_q[i]} == ctrl_q[9:7] - 3'h1) f_rel = 1'b1;
      end
   end
   assign diag = (ctrl_q[1:0] == 2'h2);

   ////////////////////////////////////////////////////////////////////////////
   a_ctrl_readback: assert property (
      $past(RD_I) && $past(ADDR_I) == rmf_pkg::REG_CTRL |-> RDATA_O[9:0] == $past(ctrl_q))
      else $error("control read differs from last write");
   a_map_guarded: assert property (
      $past(RD_I) && $past(ADDR_I) == rmf_pkg::REG_MSG_MAP |-> RDATA_O[N_MSG-1:0] == $past(mask_q))
      else $error("message map changed outside diagnostics");
   a_cycle_range: assert property (
      $past(RD_I) && $past(ADDR_I) == rmf_pkg::REG_CYCLE |-> RDATA_O <= 32'h2706)
      else $error("cycle length out of range");
   a_min_on_range: assert property (
      $past(RD_I) && $past(ADDR_I) == rmf_pkg::REG_MIN_ON |-> RDATA_O >= 32'h3)
      else $error("minimum on-time below floor");
   a_rate_range: assert property (
      $past(RD_I) && $past(ADDR_I) == rmf_pkg::REG_MAX_RATE |-> RDATA_O inside {[1:180]})
      else $error("pulse rate out of range");
   a_diag_energized: assert property (
      (diag && !f_rel) [*4] |-> RELAY_O)
      else $error("diagnostic relay dropped without fault");
   a_diag_fault: assert property (
      (diag && f_rel) [*4] |-> !RELAY_O)
      else $error("diagnostic relay held during fault");
   a_alarm_ok: assert property (
      (!f_alm) [*4] |-> ALARM_RELAY_O)
      else $error("alarm relay dropped without failure");
   a_alarm_fault: assert property (
      f_alm ##1 f_alm ##1 f_alm |-> !ALARM_RELAY_O)
      else $error("alarm relay held during failure");

   // main scenarios reached
   c_diag_drop: cover property (diag && $fell(RELAY_O));
   c_mod_pulse: cover property (!diag && $rose(RELAY_O));
   c_alarm_drop: cover property ($fell(ALARM_RELAY_O));
endmodule : rmf_relay_checker

bind rmf_relay rmf_relay_checker #(.N_MSG(N_MSG)) u_chk (
   .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
   .RD_I(RD_I), .RDATA_O(RDATA_O), .MSG_I(MSG_I), .RELAY_O(RELAY_O),
   .ALARM_RELAY_O(ALARM_RELAY_O));
`default_nettype wire

//--- tb/rmf_valve_model.sv
// partner: relay coil with actuator, times energized and idle phases
`timescale 1ns/1ps
`default_nettype none

module rmf_valve_model (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // coil
   input  wire logic coil_i,
   // last phase lengths in clocks, count of pulses
   output var  int   on_o,
   output var  int   off_o,
   output var  int   pulses_o
);
   int   run;
   logic prev;

   // pulse phase then interval phase, each timed in clocks
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         on_o     <= 0;
         off_o    <= 0;
         pulses_o <= 0;
         run      <= 0;
         prev     <= 1'b0;
      end else begin
         prev <= coil_i;
         run  <= (coil_i != prev) ? 1 : run + 1;
         if (coil_i && !prev) begin
            off_o    <= run;
            pulses_o <= pulses_o + 1;
         end
         if (!coil_i && prev) on_o <= run;
      end
   end
endmodule : rmf_valve_model
`default_nettype wire

//--- tb/rmf_relay_tb.sv
// testbench: relay modulator and fault output
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module rmf_relay_tb;
   localparam int TK = 4;
   logic        clk, rst, wr, rd, hold, relay, alarm;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, seed;
   logic [15:0] mv, msg, mask;
   logic [1:0]  cat [16];
   int          n_fail, comparisons, p_on, p_off, pulses, e;
   logic [31:0] tab [9][3] = '{'{32'h1, 32'hffff, 32'h2706}, '{32'h1, 32'h1, 32'h3},
      '{32'h2, 32'h1, 32'h3}, '{32'h1, 32'h14, 32'h14}, '{32'h2, 32'h32, 32'h14},
      '{32'h1, 32'ha, 32'h14}, '{32'h2, 32'h3, 32'h3}, '{32'h3, 32'h0, 32'h1},
      '{32'h3, 32'hc8, 32'hb4}};

   rmf_relay #(.N_MSG(16), .TICK_CYCLES(TK)) dut (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MV_I(mv), .HOLD_I(hold),
      .MSG_I(msg), .RELAY_O(relay), .ALARM_RELAY_O(alarm));
   rmf_valve_model u_valve (.clk_i(clk), .rst_i(rst), .coil_i(relay), .on_o(p_on),
      .off_o(p_off), .pulses_o(pulses));

   ////////////////////////////////////////////////////////////////////////////
   // xorshift source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // width-mode on-time in tenths, suppressed below minimum, negative as zero
   function automatic int pwm_on(input int cyc, input int mn, input int v);
      int t;
      t = (v < 0) ? 0 : cyc * v / 32767;
      return (t < mn) ? 0 : t;
   endfunction : pwm_on

   // expected fault: mode 0 by mask, else by category mode-1
   function automatic logic flt(input logic [15:0] m, input int dm);
      for (int i = 0; i < 16; i++) begin
         if (m[i] && (dm == 0 ? mask[i] : cat[i] == dm - 1)) return 1'b1;
      end
      return 1'b0;
   endfunction : flt

   task automatic tally_and_finish;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      `CHK(rdata, exp)
   endtask : rd_reg

   // waits three new pulses, then checks the last pulse and gap in clocks
   task automatic meas(input int e_on, input int e_off);
      int n0;
      int k;
      n0 = pulses;
      k  = 0;
      while (pulses < n0 + 3 && k < 4000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 4000) begin
         n_fail++;
         tally_and_finish();
      end
      `CHK(p_on, e_on)
      `CHK(p_off, e_off)
   endtask : meas

   // after the running cycle ends, relay must stay off for two cycles
   task automatic quiet;
      int hi;
      hi = 0;
      repeat (12 * TK) @(posedge clk);
      repeat (20 * TK) begin
         @(posedge clk);
         hi += int'(relay !== 1'b0);
      end
      `CHK(hi, 0)
   endtask : quiet

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, wr, rd, hold, addr, wdata, mv, msg, mask} = '0;
      rst = 1'b1;
      seed = 32'h0000bb51;
      n_fail = 0;
      comparisons = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // values after reset, unmapped places
      rd_reg(rmf_pkg::REG_CTRL, 32'h40);
      rd_reg(rmf_pkg::REG_MIN_ON, 32'h3);
      rd_reg(rmf_pkg::REG_MAX_RATE, 32'h3c);
      wr_reg(4'hc, 32'hffff);
      for (int a = 9; a < 16; a++) rd_reg(4'(a), 32'h0);
      // clamping of timing settings
      for (int i = 0; i < 9; i++) begin
         wr_reg(tab[i][0][3:0], tab[i][1]);
         rd_reg(tab[i][0][3:0], tab[i][2]);
      end
      // width mode, increasing part, random duty
      wr_reg(rmf_pkg::REG_CYCLE, 32'ha);
      wr_reg(rmf_pkg::REG_CTRL, 32'h51);
      for (int j = 0; j < 4; j++) begin
         e = 3 + int'(xs() % 7);
         mv <= 16'((e * 32767 + 9) / 10 + int'(xs() % 3000));
         meas(e * TK, (10 - e) * TK);
      end
      mv <= 16'h1b58;
      quiet();
      mv <= 16'h8001;
      quiet();
      wr_reg(rmf_pkg::REG_CTRL, 32'h49);
      mv <= 16'hc000;
      meas(5 * TK, 5 * TK);
      // hold: freeze, fixed, ignore
      wr_reg(rmf_pkg::REG_FIX_VAL, 32'h4ccd);
      for (int h = 0; h < 3; h++) begin
         wr_reg(rmf_pkg::REG_CTRL, 32'h11 | (h << 5));
         mv <= 16'h3000;
         repeat (20) @(posedge clk);
         hold <= 1'b1;
         @(posedge clk);
         mv <= 16'h7000;
         e = pwm_on(10, 3, (h == 0) ? 12288 : (h == 1) ? 19661 : 28672);
         meas(e * TK, (10 - e) * TK);
         hold <= 1'b0;
      end
      // frequency mode: full scale first, then random rate and variable
      wr_reg(rmf_pkg::REG_CTRL, 32'h55);
      for (int j = 0; j < 4; j++) begin
         e = (j == 0) ? 60 : 10 + int'(xs() % 51);
         wr_reg(rmf_pkg::REG_MAX_RATE, 32'(e));
         mv <= (j == 0) ? 16'h7fff : 16'h4000 + 16'(xs() % 32'h3fff);
         @(posedge clk);
         e = 600 / e / 2;
         meas(e * TK, e * 32767 / int'(mv) * TK);
      end
      // diagnostics: map refused outside diagnostics, then mapping and faults
      wr_reg(rmf_pkg::REG_MSG_MAP, 32'hffff);
      rd_reg(rmf_pkg::REG_MSG_MAP, 32'h0);
      wr_reg(rmf_pkg::REG_CTRL, 32'h42);
      mask = 16'(xs());
      wr_reg(rmf_pkg::REG_MSG_MAP, {16'h0, mask});
      rd_reg(rmf_pkg::REG_MSG_MAP, {16'h0, mask});
      for (int i = 0; i < 16; i++) begin
         cat[i] = 2'(xs());
         wr_reg(rmf_pkg::REG_CAT_SEL, 32'(i));
         wr_reg(rmf_pkg::REG_CAT_VAL, {30'h0, cat[i]});
         rd_reg(rmf_pkg::REG_CAT_VAL, {30'h0, cat[i]});
      end
      for (int j = 0; j < 40; j++) begin
         wr_reg(rmf_pkg::REG_CTRL, 32'h42 | ((j % 5) << 7));
         msg <= (j % 8 == 0) ? 16'h0 : 16'(xs()) & 16'(xs());
         repeat (5) @(posedge clk);
         #1;
         `CHK(relay, !flt(msg, j % 5))
         `CHK(alarm, !flt(msg, 4))
         // status word: faults, idle phase, coils
         rd_reg(rmf_pkg::REG_STATUS, 32'({flt(msg, 4), flt(msg, j % 5), 2'b00,
            !flt(msg, 4), !flt(msg, j % 5)}));
      end
      tally_and_finish();
   end
endmodule : rmf_relay_tb
`default_nettype wire
